// ===== logic/gpbc_pkg.sv
// Package for the port B and C general-purpose I/O block
package gpbc_pkg;
   localparam int unsigned      GPBC_AW         = 4;
   localparam logic [3:0]       GPBC_OFS_PB_DIR = 4'h0;
   localparam logic [3:0]       GPBC_OFS_PB_OUT = 4'h4;
   localparam logic [3:0]       GPBC_OFS_PC_DIR = 4'h8;
   localparam logic [3:0]       GPBC_OFS_PC_OUT = 4'hc;
   localparam logic [7:0]       GPBC_RST_LATCH  = 8'h00;
   localparam logic [7:0]       GPBC_RST_DIR    = 8'h00;
   localparam logic [1:0]       GPBC_RESP_OKAY  = 2'b00;
   localparam logic [1:0]       GPBC_RESP_SLVERR = 2'b10;
   localparam int unsigned      GPBC_SYNC_STAGES = 3;
   localparam int unsigned      GPBC_SMI_PIN    = 0;
   localparam int unsigned      GPBC_SCI_PIN    = 1;
endpackage

// ===== logic/gpbc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter for one 8-bit port
`timescale 1ns/1ps
`default_nettype none
module gpbc_pin_sync (
   input  wire logic       aclk,     // Bus clock
   input  wire logic       aresetn,  // Synchronous reset, active low
   input  wire logic [7:0] pin_i,    // Raw pin levels
   output logic      [7:0] level_o   // Filtered pin levels
);
   import gpbc_pkg::*;

   logic [7:0] s1_r;
   logic [7:0] s2_r;
   logic [7:0] s3_r;

   // Stages carry no reset so the sensed level follows the pins from the start
   always_ff @(posedge aclk) begin
      s1_r <= pin_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
   end

   // A change counts only once the second and third stages agree; in reset the
   // last stage is taken as is, so the sensed level is defined when reset ends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         level_o <= s3_r;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               level_o[i] <= s3_r[i];
            end
         end
      end
   end
endmodule
`default_nettype wire

// ===== logic/gpbc_top.sv
// Port B and port C general-purpose I/O with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// Function
// [R01] Port B latch, read/write, resets zero
// [R02] Port B pin-sense read returns pin levels
// [R03] Port B sense/direction share address; write loads direction
// [R04] Port B pin-sense follows pins after reset
// [R05] Port B pins 7..2 direction selects in/out
// [R06] SCI enable makes pin 1 SCI output
// [R07] SMI enable makes pin 0 SMI output
// [R08] Pull-up off on peripheral output pins
// [R09] Pull-ups off during reset
// [R10] Pull-up on: input, direction 0, latch 1
// [R11] Port C direction write-only, resets zero
// [R12] Port C latch, read/write, resets zero
// [R13] Port C pin-sense read returns pin levels
// [R14] Port C sense/direction share address; write loads direction
// [R15] Port C pin-sense follows pins after reset
// [R16] Output driver shows latch the next cycle
module gpbc_top (
   input  wire logic                      aclk,                    // Bus clock, 20 MHz
   input  wire logic                      aresetn,                 // Synchronous reset, low
   input  wire logic [gpbc_pkg::GPBC_AW-1:0] s_axi_awaddr,         // Write address
   input  wire logic                      s_axi_awvalid,           // Write address valid
   output logic                           s_axi_awready,           // Write address ready
   input  wire logic [31:0]               s_axi_wdata,             // Write data
   input  wire logic [3:0]                s_axi_wstrb,             // Write byte strobes
   input  wire logic                      s_axi_wvalid,            // Write data valid
   output logic                           s_axi_wready,            // Write data ready
   output logic [1:0]                     s_axi_bresp,             // Write response
   output logic                           s_axi_bvalid,            // Write response valid
   input  wire logic                      s_axi_bready,            // Write response ready
   input  wire logic [gpbc_pkg::GPBC_AW-1:0] s_axi_araddr,         // Read address
   input  wire logic                      s_axi_arvalid,           // Read address valid
   output logic                           s_axi_arready,           // Read address ready
   output logic [31:0]                    s_axi_rdata,             // Read data
   output logic [1:0]                     s_axi_rresp,             // Read response
   output logic                           s_axi_rvalid,            // Read data valid
   input  wire logic                      s_axi_rready,            // Read data ready
   input  wire logic                      host_sci_irq_out_enable, // SCI routing enable
   input  wire logic                      host_sci_irq_output,     // SCI level from host block
   input  wire logic                      host_smi_out_enable,     // SMI routing enable
   input  wire logic                      host_smi_output,         // SMI level from host block
   input  wire logic [7:0]                port_b_pin_i,            // Port B pin levels
   output logic      [7:0]                port_b_pin_o,            // Port B drive level
   output logic      [7:0]                port_b_pin_oe_n,         // Port B enable, low drives
   output logic      [7:0]                port_b_pullup_en,        // Port B pull-up enables
   input  wire logic [7:0]                port_c_pin_i,            // Port C pin levels
   output logic      [7:0]                port_c_pin_o,            // Port C drive level
   output logic      [7:0]                port_c_pin_oe_n          // Port C enable, low drives
);
   import gpbc_pkg::*;

   // ------------------------------------------------------------
   // Registers and bus state
   // ------------------------------------------------------------
   logic [7:0]         port_b_output_latch_r;
   logic [7:0]         port_b_direction_r;
   logic [7:0]         port_c_output_latch_r;
   logic [7:0]         port_c_direction_r;
   logic [7:0]         port_b_pin_sense;
   logic [7:0]         port_c_pin_sense;
   logic               aw_held_r;
   logic               w_held_r;
   logic [GPBC_AW-1:0] awaddr_r;
   logic [31:0]        wdata_r;
   logic               wstrb0_r;
   logic               wr_go;
   logic               rd_go;
   logic [31:0]        rdata_nxt;
   logic [1:0]         rresp_nxt;

   function automatic logic [3:0] gpbc_word(input logic [GPBC_AW-1:0] a);
      return {a[3:2], 2'b00};
   endfunction

   function automatic logic gpbc_mapped(input logic [GPBC_AW-1:0] a);
      logic [3:0] w;
      w = gpbc_word(a);
      return (w == GPBC_OFS_PB_DIR) || (w == GPBC_OFS_PB_OUT) ||
             (w == GPBC_OFS_PC_DIR) || (w == GPBC_OFS_PC_OUT);
   endfunction

   // ------------------------------------------------------------
   // Pin sensing
   // ------------------------------------------------------------
   // [R04] pin-sense tracks pins
   gpbc_pin_sync u_sync_b (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_i   (port_b_pin_i),
      .level_o (port_b_pin_sense)
   );

   // [R15] pin-sense tracks pins
   gpbc_pin_sync u_sync_c (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_i   (port_c_pin_i),
      .level_o (port_c_pin_sense)
   );

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------
   // Address and data are captured separately so either may come first
   assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         aw_held_r     <= 1'b0;
         w_held_r      <= 1'b0;
         awaddr_r      <= '0;
         wdata_r       <= 32'h0000_0000;
         wstrb0_r      <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb0_r <= s_axi_wstrb[0];
         end else if (wr_go) begin
            w_held_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= GPBC_RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= gpbc_mapped(awaddr_r) ? GPBC_RESP_OKAY : GPBC_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Port registers
   // ------------------------------------------------------------
   // Only byte lane 0 carries data; a write without lane 0 changes nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // [R01] port B latch reset
         port_b_output_latch_r <= GPBC_RST_LATCH;
         // [R12] port C latch reset
         port_c_output_latch_r <= GPBC_RST_LATCH;
      end else if (wr_go && wstrb0_r) begin
         if (gpbc_word(awaddr_r) == GPBC_OFS_PB_OUT) begin
            port_b_output_latch_r <= wdata_r[7:0];
         end else if (gpbc_word(awaddr_r) == GPBC_OFS_PC_OUT) begin
            port_c_output_latch_r <= wdata_r[7:0];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_b_direction_r <= GPBC_RST_DIR;
         // [R11] port C direction reset
         port_c_direction_r <= GPBC_RST_DIR;
      end else if (wr_go && wstrb0_r) begin
         // [R03] shared address loads direction
         if (gpbc_word(awaddr_r) == GPBC_OFS_PB_DIR) begin
            port_b_direction_r <= wdata_r[7:0];
         // [R14] shared address loads direction
         end else if (gpbc_word(awaddr_r) == GPBC_OFS_PC_DIR) begin
            port_c_direction_r <= wdata_r[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   assign rd_go = s_axi_arvalid && s_axi_arready;

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = GPBC_RESP_OKAY;
      // [R02] read returns port B pins
      if (gpbc_word(s_axi_araddr) == GPBC_OFS_PB_DIR) begin
         rdata_nxt[7:0] = port_b_pin_sense;
      end else if (gpbc_word(s_axi_araddr) == GPBC_OFS_PB_OUT) begin
         rdata_nxt[7:0] = port_b_output_latch_r;
      // [R13] read returns port C pins
      end else if (gpbc_word(s_axi_araddr) == GPBC_OFS_PC_DIR) begin
         rdata_nxt[7:0] = port_c_pin_sense;
      end else if (gpbc_word(s_axi_araddr) == GPBC_OFS_PC_OUT) begin
         rdata_nxt[7:0] = port_c_output_latch_r;
      end else begin
         rresp_nxt = GPBC_RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= GPBC_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_nxt;
            s_axi_rresp  <= rresp_nxt;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Pin drivers and pull-ups
   // ------------------------------------------------------------
   // Drivers are registered, so a register write shows on the pins one cycle later
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_b_pin_o    <= 8'h00;
         port_b_pin_oe_n <= 8'hff;
         port_c_pin_o    <= 8'h00;
         port_c_pin_oe_n <= 8'hff;
      end else begin
         // [R05] pins 7..2 follow direction
         // [R16] drive latch value
         port_b_pin_o    <= port_b_output_latch_r;
         port_b_pin_oe_n <= ~port_b_direction_r;
         port_c_pin_o    <= port_c_output_latch_r;
         port_c_pin_oe_n <= ~port_c_direction_r;
         // [R06] SCI takes pin 1
         if (host_sci_irq_out_enable) begin
            port_b_pin_o[GPBC_SCI_PIN]    <= host_sci_irq_output;
            port_b_pin_oe_n[GPBC_SCI_PIN] <= 1'b0;
         end
         // [R07] SMI takes pin 0
         if (host_smi_out_enable) begin
            port_b_pin_o[GPBC_SMI_PIN]    <= host_smi_output;
            port_b_pin_oe_n[GPBC_SMI_PIN] <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      // [R09] pull-ups off in reset
      if (!aresetn) begin
         port_b_pullup_en <= 8'h00;
      end else begin
         // [R10] input with latch 1
         port_b_pullup_en <= ~port_b_direction_r & port_b_output_latch_r;
         // [R08] off for peripheral outputs
         if (host_sci_irq_out_enable) begin
            port_b_pullup_en[GPBC_SCI_PIN] <= 1'b0;
         end
         if (host_smi_out_enable) begin
            port_b_pullup_en[GPBC_SMI_PIN] <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_latch_b_write;
      wr_go && wstrb0_r && gpbc_word(awaddr_r) == GPBC_OFS_PB_OUT;
   endsequence

   sequence s_latch_b_driven;
      ##1 (port_b_output_latch_r == $past(wdata_r[7:0]))
      ##1 (port_b_pin_o[7:2] == $past(port_b_output_latch_r[7:2]));
   endsequence

   chk_latch_b_drive: assert property (@(posedge aclk) disable iff (!aresetn) // [R01]
      s_latch_b_write |-> s_latch_b_driven)
      else $error("port B latch write not driven");

   chk_latch_c_value: assert property (@(posedge aclk) disable iff (!aresetn) // [R12]
      (wr_go && wstrb0_r && gpbc_word(awaddr_r) == GPBC_OFS_PC_OUT)
      |=> ##1 (port_c_pin_o == $past(wdata_r[7:0], 2)))
      else $error("port C latch write not driven");

   chk_dir_b_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R03]
      (wr_go && wstrb0_r && gpbc_word(awaddr_r) == GPBC_OFS_PB_DIR)
      |=> ##1 (port_b_pin_oe_n[7:2] == ~$past(wdata_r[7:2], 2)))
      else $error("port B direction write not applied");

   chk_dir_c_write: assert property (@(posedge aclk) disable iff (!aresetn) // [R14]
      (wr_go && wstrb0_r && gpbc_word(awaddr_r) == GPBC_OFS_PC_DIR)
      |=> (port_c_direction_r == $past(wdata_r[7:0])) ##1 (port_c_pin_oe_n == ~port_c_direction_r))
      else $error("port C direction write not applied");

   chk_pb_sense_read: assert property (@(posedge aclk) disable iff (!aresetn) // [R02]
      (rd_go && gpbc_word(s_axi_araddr) == GPBC_OFS_PB_DIR)
      |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(port_b_pin_sense) && s_axi_rdata[31:8] == 24'h0)
      else $error("port B sense read wrong");

   chk_pc_sense_read: assert property (@(posedge aclk) disable iff (!aresetn) // [R13]
      (rd_go && gpbc_word(s_axi_araddr) == GPBC_OFS_PC_DIR)
      |=> s_axi_rdata[7:0] == $past(port_c_pin_sense))
      else $error("port C sense read wrong");

   chk_sci_route: assert property (@(posedge aclk) disable iff (!aresetn) // [R06]
      host_sci_irq_out_enable |=> !port_b_pin_oe_n[1] && port_b_pin_o[1] == $past(host_sci_irq_output))
      else $error("SCI not routed to pin 1");

   chk_smi_route: assert property (@(posedge aclk) disable iff (!aresetn) // [R07]
      host_smi_out_enable |=> !port_b_pin_oe_n[0] && port_b_pin_o[0] == $past(host_smi_output))
      else $error("SMI not routed to pin 0");

   chk_pullup_peri: assert property (@(posedge aclk) disable iff (!aresetn) // [R08]
      (host_sci_irq_out_enable || host_smi_out_enable)
      |=> !(($past(host_sci_irq_out_enable) && port_b_pullup_en[1]) ||
            ($past(host_smi_out_enable) && port_b_pullup_en[0])))
      else $error("pull-up on at peripheral output");

   chk_pullup_rule: assert property (@(posedge aclk) disable iff (!aresetn) // [R10]
      1'b1 |=> port_b_pullup_en[7:2] ==
               (~$past(port_b_direction_r[7:2]) & $past(port_b_output_latch_r[7:2])))
      else $error("pull-up state wrong");

   chk_pullup_reset: assert property (@(posedge aclk) // [R09]
      !aresetn |=> port_b_pullup_en == 8'h00)
      else $error("pull-up on after reset");

   chk_dir_reset: assert property (@(posedge aclk) // [R11]
      !aresetn |=> port_c_direction_r == 8'h00 && port_c_pin_oe_n == 8'hff)
      else $error("port C direction not reset");

   chk_b_resp: assert property (@(posedge aclk) disable iff (!aresetn) // write response follows wr_go
      wr_go |=> s_axi_bvalid)
      else $error("write response missing");
endmodule
`default_nettype wire

// ===== bench/gpbc_pins_model.sv
// Behavioural model of the board wiring on one 8-bit port
`timescale 1ns/1ps
`default_nettype none
module gpbc_pins_model (
   input  wire logic       aclk,      // Bus clock
   input  wire logic [7:0] pin_o,     // Level the block drives
   input  wire logic [7:0] pin_oe_n,  // Low where the block drives
   input  wire logic [7:0] pullup_en, // Pull-up enables
   input  wire logic [7:0] ext_en,    // Bits driven from outside
   input  wire logic [7:0] ext_val,   // Level driven from outside
   output logic      [7:0] pin_i      // Resolved pin level
);
   logic [7:0] float_r = 8'h55;
   // Floating pins wander, so a stale level never passes for a real one
   always @(posedge aclk) begin
      float_r <= ~float_r;
   end
   always_comb begin
      for (int n = 0; n < 8; n++) begin
         if (!pin_oe_n[n]) pin_i[n] = pin_o[n];
         else if (ext_en[n]) pin_i[n] = ext_val[n];
         else if (pullup_en[n]) pin_i[n] = 1'h1;
         else pin_i[n] = float_r[n];
      end
   end
endmodule
`default_nettype wire

// ===== bench/gpbc_top_tb.sv
// Self-checking bench for the port B and C I/O block
`timescale 1ns/1ps
`default_nettype none
module gpbc_top_tb;
   import gpbc_pkg::*;
   logic        aclk = 1'h0, aresetn = 1'h0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        sci_en = 1'h0, sci_lvl = 1'h0, smi_en = 1'h0, smi_lvl = 1'h0;
   logic [7:0]  b_i, b_o, b_oe_n, b_pu, c_i, c_o, c_oe_n;
   logic [7:0]  b_ext_en = 8'hff, b_ext = 8'h00, c_ext_en = 8'hff, c_ext = 8'h00;
   int          n_errors = 0, compares = 0, cycles = 0;
   // Xorshift state, starts at 86030
   logic [31:0] seed = 32'h0001500e;

   always #25 aclk = ~aclk;
   // Hang guard, far above the several hundred cycles the run needs
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         complete_run();
      end
   end

   gpbc_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .host_sci_irq_out_enable(sci_en),
      .host_sci_irq_output(sci_lvl), .host_smi_out_enable(smi_en),
      .host_smi_output(smi_lvl), .port_b_pin_i(b_i), .port_b_pin_o(b_o),
      .port_b_pin_oe_n(b_oe_n), .port_b_pullup_en(b_pu), .port_c_pin_i(c_i),
      .port_c_pin_o(c_o), .port_c_pin_oe_n(c_oe_n));
   gpbc_pins_model pb_u (.aclk(aclk), .pin_o(b_o), .pin_oe_n(b_oe_n), .pullup_en(b_pu),
      .ext_en(b_ext_en), .ext_val(b_ext), .pin_i(b_i));
   gpbc_pins_model pc_u (.aclk(aclk), .pin_o(c_o), .pin_oe_n(c_oe_n), .pullup_en(8'h00),
      .ext_en(c_ext_en), .ext_val(c_ext), .pin_i(c_i));

   // ------------------------------------------------------------
   // Helpers and expectations
   // ------------------------------------------------------------
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [7:0] exp_oe(input logic [7:0] d);
      exp_oe = ~d;
      if (sci_en) exp_oe[1] = 1'h0;
      if (smi_en) exp_oe[0] = 1'h0;
   endfunction
   function automatic logic [7:0] exp_drv(input logic [7:0] l);
      exp_drv = l;
      if (sci_en) exp_drv[1] = sci_lvl;
      if (smi_en) exp_drv[0] = smi_lvl;
   endfunction
   function automatic logic [7:0] exp_pu(input logic [7:0] d, input logic [7:0] l);
      exp_pu = ~d & l;
      if (sci_en) exp_pu[1] = 1'h0;
      if (smi_en) exp_pu[0] = 1'h0;
   endfunction
   // Returns {mask, level}; floating bits are left out of the mask
   function automatic logic [15:0] exp_sense(input logic [7:0] oe_n, o, pu, en, ext);
      logic [7:0] m;
      m = ~oe_n | en | pu;
      return {m, (~oe_n & o) | (oe_n & en & ext) | (oe_n & ~en & pu)};
   endfunction
   task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk_resp(input string what, input logic [1:0] e, input logic [1:0] g);
      compares++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, input logic [3:0] st);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      chk_resp("write resp", GPBC_RESP_OKAY, s_axi_bresp);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      chk_resp("read resp", GPBC_RESP_OKAY, s_axi_rresp);
      s_axi_rready <= 1'h0;
   endtask
   task automatic complete_run();
      $display("compares %0d errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0]  db, lb, dc, lc, m;
      logic [31:0] r;
      logic [15:0] s;
      repeat (2) @(posedge aclk);
      chk_word("pull-ups in reset", 32'h0, {24'h0, b_pu});
      aresetn <= 1'h1;
      @(posedge aclk);
      rd_reg(GPBC_OFS_PB_OUT, r);
      chk_word("b latch reset", {24'h0, GPBC_RST_LATCH}, r);
      rd_reg(GPBC_OFS_PC_OUT, r);
      chk_word("c latch reset", {24'h0, GPBC_RST_LATCH}, r);
      chk_word("c oe_n reset", 32'hff, {24'h0, c_oe_n});
      $display("test reset done");
      for (int i = 0; i < 16; i++) begin
         // First two passes: port B pull-ups on pins 7..2 with both host outputs, then all port B outputs
         if (i == 0) {db, lb, dc, lc} = 32'h00ff_ff00;
         else if (i == 1) {db, lb, dc, lc} = 32'hff00_00ff;
         else {db, lb, dc, lc} = {rnd(), rnd(), rnd(), rnd()};
         m = rnd();
         {sci_en, sci_lvl, smi_en, smi_lvl} <= (i == 0) ? {1'h1, m[1], 1'h1, m[2]} : m[3:0];
         b_ext_en <= rnd();
         b_ext <= rnd();
         c_ext_en <= rnd();
         c_ext <= rnd();
         wr_reg(GPBC_OFS_PB_DIR, db, 4'hf);
         wr_reg(GPBC_OFS_PB_OUT, lb, 4'hf);
         wr_reg(GPBC_OFS_PC_DIR, dc, 4'hf);
         wr_reg(GPBC_OFS_PC_OUT, lc, 4'hf);
         repeat (8) @(posedge aclk);
         m = ~exp_oe(db);
         chk_word("b oe_n", {24'h0, exp_oe(db)}, {24'h0, b_oe_n});
         chk_word("b drive", {24'h0, exp_drv(lb) & m}, {24'h0, b_o & m});
         chk_word("b pull-up", {24'h0, exp_pu(db, lb)}, {24'h0, b_pu});
         chk_word("c oe_n", {24'h0, ~dc}, {24'h0, c_oe_n});
         chk_word("c drive", {24'h0, lc & dc}, {24'h0, c_o & dc});
         s = exp_sense(exp_oe(db), exp_drv(lb), exp_pu(db, lb), b_ext_en, b_ext);
         rd_reg(GPBC_OFS_PB_DIR, r);
         chk_word("b sense", {24'h0, s[7:0]}, r & {24'h0, s[15:8]});
         s = exp_sense(~dc, lc, 8'h00, c_ext_en, c_ext);
         rd_reg(GPBC_OFS_PC_DIR, r);
         chk_word("c sense", {24'h0, s[7:0]}, r & {24'h0, s[15:8]});
         rd_reg(GPBC_OFS_PB_OUT, r);
         chk_word("b latch", {24'h0, lb}, r);
         rd_reg(GPBC_OFS_PC_OUT, r);
         chk_word("c latch", {24'h0, lc}, r);
         $display("test pass %0d done", i);
      end
      // A write with its low byte lane off must leave the latch alone
      wr_reg(GPBC_OFS_PB_OUT, ~lb, 4'he);
      rd_reg(GPBC_OFS_PB_OUT, r);
      chk_word("b latch strobe off", {24'h0, lb}, r);
      $display("test strobe done");
      complete_run();
   end
endmodule
`default_nettype wire
